// >>> pkg/dshp_pkg.sv
// dshp_pkg: constants and types of the dual serial host port.
// assumes: included first; register map offsets are the block's own.
package dshp_pkg;
  // ==========================================================
  // bus identity and framing
  localparam logic [5:0] I2C_ADDR_HI    = 6'h0c;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0] SPI_LAST_BIT   = 3'h7;
  // ==========================================================
  // register map
  localparam logic [6:0] ADDR_TRIM_SENS = 7'h10;
  localparam logic [6:0] ADDR_TRIM_OFS  = 7'h11;
  localparam logic [6:0] ADDR_CTRL      = 7'h20;
  localparam logic [6:0] ADDR_STATUS    = 7'h27;
  localparam logic [6:0] ADDR_OUT_XL    = 7'h28;
  localparam logic [6:0] ADDR_OUT_ZH    = 7'h2d;
  localparam logic [6:0] ADDR_INT_BASE  = 7'h30;
  localparam logic [6:0] INT_STRIDE     = 7'h04;
  localparam logic [6:0] INT_OFS_CFG    = 7'h00;
  localparam logic [6:0] INT_OFS_SRC    = 7'h01;
  localparam logic [6:0] INT_OFS_THS    = 7'h02;
  localparam logic [6:0] INT_OFS_DUR    = 7'h03;
  // ==========================================================
  // field positions and reset values
  localparam int         CTRL_3WIRE_BIT = 0;
  localparam int         STATUS_NEW_BIT = 3;
  localparam int         SRC_ACTIVE_BIT = 6;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // ==========================================================
  // types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dshp_acc_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } dshp_sample_t;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_SUB, I_SACK, I_WR, I_WACK, I_RD, I_MACK
  } dshp_i2c_st_t;
endpackage

// >>> rtl/dshp_regfile.sv
// dshp_regfile: register store, trim load, data-ready and two inertial interrupts.
// assumes: one access per cycle from the serial front end; samples on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dshp_regfile (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire dshp_pkg::dshp_acc_t  acc,
  input  wire logic [6:0]           rd_addr,
  output logic [7:0]                rdata,
  output logic                      three_wire,
  input  wire logic                 core_pwr_ok,
  input  wire logic                 sample_valid,
  input  wire dshp_pkg::dshp_sample_t sample,
  input  wire logic [7:0]           nvm_sens,
  input  wire logic [7:0]           nvm_ofs,
  output logic                      data_ready,
  output logic [1:0]                int_out,
  output logic                      trim_done
);
  logic [7:0] mem_q [128];
  logic [7:0] mem_d [128];
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];
  logic       drdy_q, drdy_d, trim_q, trim_d;
  logic [1:0] int_q, int_d;
  logic       take;

  function automatic logic read_only(input logic [6:0] a);
    logic ro;
    ro = (a == dshp_pkg::ADDR_STATUS) ||
         (a >= dshp_pkg::ADDR_OUT_XL && a <= dshp_pkg::ADDR_OUT_ZH);
    for (int n = 0; n < 2; n++)
      ro = ro || (a == dshp_pkg::ADDR_INT_BASE + 7'(n) * dshp_pkg::INT_STRIDE + dshp_pkg::INT_OFS_SRC);
    return ro;
  endfunction

  function automatic logic [7:0] mag(input logic [7:0] v);
    return v[7] ? 8'(-v) : v;
  endfunction

  assign rdata      = mem_q[rd_addr];
  assign three_wire = mem_q[dshp_pkg::ADDR_CTRL][dshp_pkg::CTRL_3WIRE_BIT];
  assign data_ready = drdy_q;
  assign int_out    = int_q;
  assign trim_done  = trim_q;
  // measurement chain is off without core supply; nothing is captured then
  assign take = sample_valid && core_pwr_ok && trim_q; // [R10]

  // ==========================================================
  // next state
  always_comb
  begin
    logic [6:0] b;
    logic [2:0] over;
    logic       hit;
    logic [7:0] c;
    b = 7'h00;
    over = 3'h0;
    hit = 1'b0;
    c = 8'h00;
    mem_d  = mem_q;
    cnt_d  = cnt_q;
    int_d  = int_q;
    trim_d = 1'b1;
    drdy_d = drdy_q;
    if (!trim_q)
    begin
      mem_d[dshp_pkg::ADDR_TRIM_SENS] = nvm_sens; // [R09]
      mem_d[dshp_pkg::ADDR_TRIM_OFS]  = nvm_ofs;  // [R09]
    end
    if (acc.wr && !read_only(acc.addr))
      mem_d[acc.addr] = acc.wdata; // [R04]
    if (acc.rd && acc.addr == dshp_pkg::ADDR_OUT_ZH)
      drdy_d = 1'b0;
    if (take)
    begin
      drdy_d = 1'b1; // [R06]
      {mem_d[dshp_pkg::ADDR_OUT_XL + 7'h1], mem_d[dshp_pkg::ADDR_OUT_XL]} = sample.x;
      {mem_d[dshp_pkg::ADDR_OUT_XL + 7'h3], mem_d[dshp_pkg::ADDR_OUT_XL + 7'h2]} = sample.y;
      {mem_d[dshp_pkg::ADDR_OUT_ZH], mem_d[dshp_pkg::ADDR_OUT_XL + 7'h4]} = sample.z;
      for (int n = 0; n < 2; n++)
      begin
        b = dshp_pkg::ADDR_INT_BASE + 7'(n) * dshp_pkg::INT_STRIDE;
        over[0] = mag(sample.x[15:8]) > {1'b0, mem_q[b + dshp_pkg::INT_OFS_THS][6:0]}; // [R08]
        over[1] = mag(sample.y[15:8]) > {1'b0, mem_q[b + dshp_pkg::INT_OFS_THS][6:0]};
        over[2] = mag(sample.z[15:8]) > {1'b0, mem_q[b + dshp_pkg::INT_OFS_THS][6:0]};
        over = over & mem_q[b + dshp_pkg::INT_OFS_CFG][2:0]; // [R07]
        hit = |over;
        c = !hit ? 8'h00 : (&cnt_q[n]) ? cnt_q[n] : 8'(cnt_q[n] + 8'h01);
        cnt_d[n] = c;
        int_d[n] = hit && (c >= mem_q[b + dshp_pkg::INT_OFS_DUR]); // [R08]
        mem_d[b + dshp_pkg::INT_OFS_SRC] = 8'(({7'h00, int_d[n]} << dshp_pkg::SRC_ACTIVE_BIT) | {5'h00, over});
      end
    end
    mem_d[dshp_pkg::ADDR_STATUS] = 8'({7'h00, drdy_d} << dshp_pkg::STATUS_NEW_BIT);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 128; i++)
        mem_q[i] <= dshp_pkg::RESET_BYTE;
      cnt_q[0] <= 8'h00;
      cnt_q[1] <= 8'h00;
      int_q    <= 2'h0;
      drdy_q   <= 1'b0;
      trim_q   <= 1'b0;
    end
    else
    begin
      mem_q  <= mem_d;
      cnt_q  <= cnt_d;
      int_q  <= int_d;
      drdy_q <= drdy_d;
      trim_q <= trim_d;
    end
  end

  // ==========================================================
  // checks
  a_trim_copy: assert property (@(posedge clock) disable iff (rst) // [R09]
    $rose(trim_q) |-> mem_q[dshp_pkg::ADDR_TRIM_SENS] == $past(nvm_sens))
    else $error("trim value not copied at start-up");
  a_drdy_sets: assert property (@(posedge clock) disable iff (rst) // [R06]
    take |=> drdy_q && mem_q[dshp_pkg::ADDR_STATUS][dshp_pkg::STATUS_NEW_BIT])
    else $error("data ready missing after sample");
  a_write_lands: assert property (@(posedge clock) disable iff (rst) // [R04]
    (acc.wr && !read_only(acc.addr) && acc.addr != dshp_pkg::ADDR_STATUS) |=> mem_q[$past(acc.addr)] == $past(acc.wdata))
    else $error("register write lost");
endmodule
`default_nettype wire

// >>> rtl/dshp_port.sv
// dshp_port: shared-pad two-wire and serial peripheral slave front end.
// assumes: pads are asynchronous to clock; bench link clock far below clock rate.
// Notes on behaviour
// R01 - select pin high runs two-wire slave; low enables serial peripheral port
// R02 - software picks three-wire shared data or four-wire separate data lines
// R03 - both ports share pads and reach one common register set
// R04 - two-wire side is slave only; writes stored, reads return stored contents
// R05 - two-wire slave works at fast mode and standard mode clock rates
// R06 - data-ready output rises when a full three-axis sample set is stored
// R07 - inertial events on enabled axes drive two separate interrupt pins independently
// R08 - each interrupt's function, threshold and duration are host programmable
// R09 - factory trim is copied from non-volatile store into registers at power-up
// R10 - without core supply the bus is never held; measurement stops
// R11 - two-wire data is bidirectional; lines rest high when idle
// R12 - seven-bit address has fixed upper six bits; strap sets the lowest
// R13 - sub-address follows: low seven bits select register, top bit auto-increments
// R14 - peripheral frame: read bit, increment bit, six-bit address, then data
// R15 - sixteen clocks per access, eight more per byte; shift on fall, sample on rise
// R16 - while peripheral port is selected, two-wire logic ignores pads and stays off
`timescale 1ns/10ps
`default_nettype none
module dshp_port (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   if_select,
  input  wire logic                   scl_pclk_in,
  input  wire logic                   sda_sdi_in,
  output logic                        sda_sdi_out,
  output logic                        sda_sdi_oe,
  input  wire logic                   sdo_strap_in,
  output logic                        sdo_strap_out,
  output logic                        sdo_strap_oe,
  input  wire logic                   core_pwr_ok,
  input  wire logic                   sample_valid,
  input  wire dshp_pkg::dshp_sample_t sample,
  input  wire logic [7:0]             nvm_sens,
  input  wire logic [7:0]             nvm_ofs,
  output logic                        data_ready,
  output logic                        int1,
  output logic                        int2,
  output logic                        trim_done
);
  // ==========================================================
  // pad synchronisers: 0 select, 1 clock, 2 data, 3 strap
  logic [3:0] s1_q, s2_q, p_q;
  logic       i2c_mode, scl_rise, scl_fall, start, stop, pclk_rise, pclk_fall, frame_go;

  // clock runs far above the 400 kHz bus clock, so edges are found by oversampling
  always_ff @(posedge clock or posedge rst) // [R05]
  begin
    if (rst)
    begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      p_q  <= 4'hf;
    end
    else
    begin
      s1_q <= {sdo_strap_in, sda_sdi_in, scl_pclk_in, if_select};
      s2_q <= s1_q;
      p_q  <= s2_q;
    end
  end

  assign i2c_mode = s2_q[0]; // [R01]
  assign scl_rise = s2_q[1] && !p_q[1];
  assign scl_fall = !s2_q[1] && p_q[1];
  assign start    = i2c_mode && s2_q[1] && p_q[1] && !s2_q[2] && p_q[2];
  assign stop     = i2c_mode && s2_q[1] && p_q[1] && s2_q[2] && !p_q[2];
  assign pclk_rise = !i2c_mode && scl_rise; // [R15]
  assign pclk_fall = !i2c_mode && scl_fall; // [R15]
  assign frame_go = !s2_q[0] && p_q[0];

  // ==========================================================
  // register store
  dshp_pkg::dshp_acc_t acc_q, acc_d;
  logic [6:0] ptr_q, ptr_d;
  logic [7:0] rdata;
  logic       three_wire;
  logic [1:0] int_w;

  dshp_regfile u_regs (
    .clock        (clock),
    .rst          (rst),
    .acc          (acc_q), // [R03]
    .rd_addr      (ptr_q),
    .rdata        (rdata),
    .three_wire   (three_wire),
    .core_pwr_ok  (core_pwr_ok),
    .sample_valid (sample_valid),
    .sample       (sample),
    .nvm_sens     (nvm_sens),
    .nvm_ofs      (nvm_ofs),
    .data_ready   (data_ready),
    .int_out      (int_w),
    .trim_done    (trim_done)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      int1 <= 1'b0;
      int2 <= 1'b0;
    end
    else
    begin
      int1 <= int_w[0]; // [R07]
      int2 <= int_w[1]; // [R07]
    end
  end

  // ==========================================================
  // protocol engines: one pointer and one access port for both, so both reach the same registers
  dshp_pkg::dshp_i2c_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] sp_cnt_q, sp_cnt_d;
  logic       rw_q, rw_d, ai_q, ai_d, strap_q, strap_d;
  logic       hdr_q, hdr_d, sp_rw_q, sp_rw_d, inc_q, inc_d;
  logic       ack_q, ack_d, bit_q, bit_d;
  logic [7:0] rx_byte;

  assign rx_byte = {sh_q[6:0], s2_q[2]};

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    sp_cnt_d = sp_cnt_q;
    rw_d = rw_q;
    ai_d = ai_q;
    hdr_d = hdr_q;
    sp_rw_d = sp_rw_q;
    inc_d = inc_q;
    ack_d = ack_q;
    bit_d = bit_q;
    ptr_d = ptr_q;
    strap_d = strap_q;
    acc_d = '0;
    if (!i2c_mode)
    begin
      // two-wire engine held idle and silent while the peripheral port owns the pads
      st_d  = dshp_pkg::I_IDLE; // [R16]
      ack_d = 1'b0;             // [R16]
      if (frame_go)
      begin
        hdr_d = 1'b0;
        sp_cnt_d = 3'h0;
        bit_d = 1'b0;
      end
      else if (pclk_rise)
      begin
        sh_d = rx_byte; // [R15]
        sp_cnt_d = 3'(sp_cnt_q + 3'h1);
        if (sp_cnt_q == dshp_pkg::SPI_LAST_BIT)
        begin
          if (!hdr_q)
          begin
            hdr_d   = 1'b1;               // [R14]
            sp_rw_d = sh_q[6];            // [R14]
            inc_d   = sh_q[5];            // [R14]
            ptr_d   = {1'b0, rx_byte[5:0]}; // [R14]
          end
          else if (!sp_rw_q)
          begin
            acc_d = '{wr: 1'b1, rd: 1'b0, addr: ptr_q, wdata: rx_byte}; // [R04]
            ptr_d = {1'b0, 6'(ptr_q[5:0] + {5'h00, inc_q})};            // [R15]
          end
        end
      end
      else if (pclk_fall && hdr_q && sp_rw_q)
      begin
        if (sp_cnt_q == 3'h0)
        begin
          tx_d  = rdata; // [R14]
          bit_d = rdata[7];
          acc_d = '{wr: 1'b0, rd: 1'b1, addr: ptr_q, wdata: 8'h00};
          ptr_d = {1'b0, 6'(ptr_q[5:0] + {5'h00, inc_q})};
        end
        else
        begin
          tx_d  = {tx_q[6:0], 1'b0};
          bit_d = tx_q[6];
        end
      end
    end
    else if (start)
    begin
      st_d  = dshp_pkg::I_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      hdr_d = 1'b0;
    end
    else if (stop)
    begin
      st_d  = dshp_pkg::I_IDLE; // [R11]
      ack_d = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (st_q)
        dshp_pkg::I_ADDR, dshp_pkg::I_SUB, dshp_pkg::I_WR:
        begin
          sh_d  = rx_byte;
          cnt_d = 4'(cnt_q + 4'h1);
        end
        dshp_pkg::I_MACK:
          if (s2_q[2])
            st_d = dshp_pkg::I_IDLE;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (st_q)
        dshp_pkg::I_ADDR:
          if (cnt_q == dshp_pkg::BITS_PER_BYTE)
          begin
            if (sh_q[7:1] == {dshp_pkg::I2C_ADDR_HI, strap_q}) // [R12]
            begin
              st_d  = dshp_pkg::I_AACK;
              ack_d = 1'b1;
              rw_d  = sh_q[0];
            end
            else
              st_d = dshp_pkg::I_IDLE;
          end
        dshp_pkg::I_AACK, dshp_pkg::I_MACK:
        begin
          cnt_d = 4'h0;
          ack_d = 1'b0;
          st_d  = dshp_pkg::I_SUB;
          if (rw_q || st_q == dshp_pkg::I_MACK)
          begin
            sh_d  = rdata; // [R04]
            ack_d = !rdata[7];
            cnt_d = 4'h1;
            acc_d = '{wr: 1'b0, rd: 1'b1, addr: ptr_q, wdata: 8'h00};
            st_d  = dshp_pkg::I_RD;
          end
        end
        dshp_pkg::I_SUB:
          if (cnt_q == dshp_pkg::BITS_PER_BYTE)
          begin
            ptr_d = sh_q[6:0]; // [R13]
            ai_d  = sh_q[7];   // [R13]
            ack_d = 1'b1;
            st_d  = dshp_pkg::I_SACK;
          end
        dshp_pkg::I_SACK, dshp_pkg::I_WACK:
        begin
          ack_d = 1'b0;
          cnt_d = 4'h0;
          st_d  = dshp_pkg::I_WR;
          if (st_q == dshp_pkg::I_WACK)
            ptr_d = 7'(ptr_q + {6'h00, ai_q}); // [R13]
        end
        dshp_pkg::I_WR:
          if (cnt_q == dshp_pkg::BITS_PER_BYTE)
          begin
            acc_d = '{wr: 1'b1, rd: 1'b0, addr: ptr_q, wdata: sh_q}; // [R04]
            ack_d = 1'b1;
            st_d  = dshp_pkg::I_WACK;
          end
        dshp_pkg::I_RD:
          if (cnt_q == dshp_pkg::BITS_PER_BYTE)
          begin
            ack_d = 1'b0;
            ptr_d = 7'(ptr_q + {6'h00, ai_q}); // [R13]
            st_d  = dshp_pkg::I_MACK;
          end
          else
          begin
            sh_d  = {sh_q[6:0], 1'b0};
            ack_d = !sh_q[6];
            cnt_d = 4'(cnt_q + 4'h1);
          end
        default: ;
      endcase
    end
    // the strap pad doubles as peripheral data out, so it is only read while idle on two-wire
    if (i2c_mode && st_q == dshp_pkg::I_IDLE)
      strap_d = s2_q[3]; // [R12]
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= dshp_pkg::I_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      sp_cnt_q <= 3'h0;
      rw_q <= 1'b0;
      ai_q <= 1'b0;
      hdr_q <= 1'b0;
      sp_rw_q <= 1'b0;
      inc_q <= 1'b0;
      ack_q <= 1'b0;
      bit_q <= 1'b0;
      ptr_q <= 7'h00;
      strap_q <= 1'b0;
      acc_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      sp_cnt_q <= sp_cnt_d;
      rw_q <= rw_d;
      ai_q <= ai_d;
      hdr_q <= hdr_d;
      sp_rw_q <= sp_rw_d;
      inc_q <= inc_d;
      ack_q <= ack_d;
      bit_q <= bit_d;
      ptr_q <= ptr_d;
      strap_q <= strap_d;
      acc_q <= acc_d;
    end
  end

  // ==========================================================
  // pad drivers: two-wire data is open drain and never held outside a byte, so the bus stays free
  logic sda_out_d, sda_oe_d, sdo_out_d, sdo_oe_d, sp_drive;

  assign sp_drive = !i2c_mode && hdr_q && sp_rw_q;

  always_comb
  begin
    sda_out_d = 1'b0;
    sda_oe_d  = i2c_mode && ack_q; // [R10] [R11]
    sdo_out_d = bit_q;
    sdo_oe_d  = 1'b0;
    if (sp_drive)
    begin
      if (three_wire)
      begin
        sda_out_d = bit_q; // [R02]
        sda_oe_d  = 1'b1;  // [R02]
      end
      else
        sdo_oe_d = 1'b1;   // [R02]
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sda_sdi_out   <= 1'b0;
      sda_sdi_oe    <= 1'b0;
      sdo_strap_out <= 1'b0;
      sdo_strap_oe  <= 1'b0;
    end
    else
    begin
      sda_sdi_out   <= sda_out_d;
      sda_sdi_oe    <= sda_oe_d;
      sdo_strap_out <= sdo_out_d;
      sdo_strap_oe  <= sdo_oe_d;
    end
  end

  // ==========================================================
  // checks
  a_spi_mutes_i2c: assert property (@(posedge clock) disable iff (rst) // [R16]
    !i2c_mode |=> st_q == dshp_pkg::I_IDLE && !ack_q ##1 !(sda_sdi_oe && !three_wire))
    else $error("two-wire engine active in peripheral mode");
  a_addr_reject: assert property (@(posedge clock) disable iff (rst) // [R12]
    (i2c_mode && !start && !stop && scl_fall && st_q == dshp_pkg::I_ADDR && cnt_q == dshp_pkg::BITS_PER_BYTE
     && sh_q[7:1] != {dshp_pkg::I2C_ADDR_HI, strap_q}) |=> st_q == dshp_pkg::I_IDLE ##1 !sda_sdi_oe)
    else $error("foreign address acknowledged");
  a_sub_pointer: assert property (@(posedge clock) disable iff (rst) // [R13]
    (i2c_mode && !start && !stop && scl_fall && st_q == dshp_pkg::I_SUB && cnt_q == dshp_pkg::BITS_PER_BYTE)
    |=> ptr_q == $past(sh_q[6:0]) && ai_q == $past(sh_q[7]) && ack_q ##1 sda_sdi_oe)
    else $error("sub-address not taken");
  a_spi_header: assert property (@(posedge clock) disable iff (rst) // [R14]
    (pclk_rise && !frame_go && !hdr_q && sp_cnt_q == dshp_pkg::SPI_LAST_BIT)
    |=> hdr_q && ptr_q[5:0] == $past(rx_byte[5:0]) && sp_rw_q == $past(sh_q[6]))
    else $error("peripheral header misread");
  a_spi_byte_edge: assert property (@(posedge clock) disable iff (rst) // [R15]
    (acc_q.wr && !i2c_mode) |-> $past(sp_cnt_q == dshp_pkg::SPI_LAST_BIT && hdr_q && pclk_rise))
    else $error("peripheral write off byte boundary");
  a_idle_release: assert property (@(posedge clock) disable iff (rst) // [R11]
    (i2c_mode && st_q == dshp_pkg::I_IDLE) |-> !ack_q ##1 !sda_sdi_oe)
    else $error("data line held while idle");
  a_sdo_read_only: assert property (@(posedge clock) disable iff (rst) // [R14]
    sdo_strap_oe |-> $past(sp_drive && !three_wire))
    else $error("output pad driven outside a read");
endmodule
`default_nettype wire

// >>> sim/dshp_master.sv
// dshp_master: serial bus master model driving the shared pads of the host port.
// assumes: the bench resolves the pads and routes the line to read onto rd_line.
`timescale 1ns/10ps
`default_nettype none
module dshp_master (
  input  wire logic rd_line,
  output logic      scl,
  output logic      sd,
  output logic      sel
);
  // ======================================
  // bit timing: low 44 ns, high 20 ns; the long low phase lets answers land before the rise
  initial
  begin
    scl = 1'b1;  // lines rest high
    sd  = 1'b1;
    sel = 1'b1;  // two-wire unless a frame runs
  end
  task automatic xb(input logic b, output logic r);
    scl = 1'b0;
    #12 sd = b;  // data moves only while the clock is low
    #32 r = rd_line;
    scl = 1'b1;  // device samples on the rise
    #20;
  endtask
  task automatic byte9(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      xb(w[i], r[i]);  // msb first, ninth bit is the ack
  endtask
  // data moves with the clock high: (1,0) start, (0,1) stop
  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    #12 sd = a;
    #32 scl = 1'b1;
    #20 sd = b;
    #40;
  endtask
  task automatic frame(input logic [15:0] f, output logic [15:0] r);
    sel = 1'b0;  // peripheral port selected
    #40;
    for (int i = 15; i >= 0; i--)
      xb(f[i], r[i]);  // rw, increment, address, data in sixteen pulses
    #40 sel = 1'b1;
    sd = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> sim/dshp_port_tb.sv
// dshp_port_tb: self-checking bench for the dual serial host port.
// assumes: dshp_master drives the pads; pads are resolved here with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module dshp_port_tb;
  logic                   clock, rst, strap, rsel, core_pwr_ok, sample_valid, sda_w, sdo_w, rd_line;
  logic                   scl, sd, sel, sda_sdi_out, sda_sdi_oe, sdo_strap_out, sdo_strap_oe;
  logic                   data_ready, int1, int2, trim_done;
  logic [31:0]            q;
  dshp_pkg::dshp_sample_t sample;
  int                     bad_count, checked;
  // ======================================
  // pads and instances
  assign sda_w   = (sda_sdi_oe ? sda_sdi_out : 1'b1) & sd;  // open drain with pull-up
  assign sdo_w   = sdo_strap_oe ? sdo_strap_out : strap;
  assign rd_line = rsel ? sdo_w : sda_w;
  always #4 clock = ~clock;
  dshp_master m (.rd_line, .scl, .sd, .sel);
  dshp_port dut (
    .clock, .rst, .if_select(sel), .scl_pclk_in(scl), .sda_sdi_in(sda_w), .sda_sdi_out, .sda_sdi_oe,
    .sdo_strap_in(sdo_w), .sdo_strap_out, .sdo_strap_oe, .core_pwr_ok, .sample_valid, .sample,
    .nvm_sens(8'h5a), .nvm_ofs(8'ha7), .data_ready, .int1, .int2, .trim_done);
  // ======================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // start, address and sub-address; a is the or of the ack bits
  task automatic hdr(input logic [7:0] sub, input logic ak, output logic a);
    logic [8:0] r;
    m.cond(1'b1, 1'b0);
    m.byte9({dshp_pkg::I2C_ADDR_HI, strap ^ !ak, 2'b01}, r);
    a = r[0];
    m.byte9({sub, 1'b1}, r);
    a = a | r[0];
  endtask
  task automatic iw(input logic [7:0] sub, input logic [31:0] d, input int n, input logic ak);
    logic [8:0] r;
    logic       a;
    hdr(sub, ak, a);
    for (int k = n - 1; k >= 0; k--)
    begin
      m.byte9({d[8*k +: 8], 1'b1}, r);
      a = a | r[0];
    end
    m.cond(1'b0, 1'b1);
    chk("write ack", !ak, a);
  endtask
  task automatic ir(input logic [7:0] sub, input int n);
    logic [8:0] r;
    logic       a;
    hdr(sub, 1'b1, a);
    m.cond(1'b1, 1'b0);
    m.byte9({dshp_pkg::I2C_ADDR_HI, strap, 2'b11}, r);
    a = a | r[0];
    q = '0;
    for (int k = n - 1; k >= 0; k--)
    begin
      m.byte9({8'hff, k == 0}, r);  // master nack on the last byte ends the read
      q = {q[23:0], r[8:1]};
    end
    m.cond(1'b0, 1'b1);
    chk("read ack", 0, a);
  endtask
  task automatic sp(input logic [15:0] f);
    logic [15:0] r;
    m.frame(f, r);
    q = {24'h0, r[7:0]};
  endtask
  task automatic pulse(input dshp_pkg::dshp_sample_t s);
    @(posedge clock);
    #1 sample = s;
    sample_valid = 1'b1;
    @(posedge clock);
    #1 sample_valid = 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // ======================================
  // tests
  always @(posedge clock)
    if (rsel && sda_sdi_oe !== 1'b0)
      chk("sda oe", 0, sda_sdi_oe);
  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    strap = 1'b1;
    rsel = 1'b0;
    core_pwr_ok = 1'b1;
    sample_valid = 1'b0;
    sample = '0;
    bad_count = 0;
    checked = 0;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    chk("trim_done", 1, trim_done);
    #1;
    ir(8'h90, 2);
    chk("trim regs", 32'h5aa7, q);
    $display("test trim ended");
    iw(8'h32, 32'h2a, 1, 1'b1);
    iw(8'h32, 32'h55, 1, 1'b0);  // other strap address gets no ack
    ir(8'h32, 1);
    chk("threshold", 32'h2a, q);
    strap = 1'b0;
    iw(8'hb0, 32'h07001001, 4, 1'b1);  // strap low moves the address
    iw(8'hb4, 32'h07001001, 4, 1'b1);
    ir(8'hb4, 4);
    chk("int2 setup", 32'h07001001, q);
    $display("test two-wire ended");
    rsel = 1'b1;
    sp(16'h3622);
    sp(16'hb6ff);
    chk("spi read", 32'h22, q);
    sp(16'h2001);
    rsel = 1'b0;
    sp(16'ha0ff);
    chk("three-wire read", 32'h01, q);
    sp(16'h2000);
    ir(8'h36, 1);
    chk("shared regs", 32'h22, q);
    $display("test peripheral ended");
    pulse({16'h4000, 16'h0123, 16'h0005});
    chk("ready and ints", 3'h7, {data_ready, int1, int2});
    ir(8'ha8, 4);
    chk("samples", 32'h00402301, q);
    ir(8'h31, 1);
    chk("int1 source", 32'h41, q);
    ir(8'h2d, 1);
    chk("z high", 32'h00, q);
    chk("ready cleared", 0, data_ready);
    #1 core_pwr_ok = 1'b0;
    pulse({16'h4000, 16'h0123, 16'h0005});
    chk("no sample", 0, data_ready);
    ir(8'h20, 1);
    chk("bus alive", 32'h00, q);
    $display("test samples ended");
    conclude();
  end
endmodule
`default_nettype wire
